/* File: rtl/spi_eeprom_pin_front_end.sv */
// Serial pin front end: selection, pause, bit shifting and volatile status.
// Assumes all pins are asynchronous to clk_sys_i and the serial clock
// is several system clocks per phase.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Output bit changes after serial clock fall
// - Input bit sampled on serial clock rise
// - Deselected means output tri-stated
// - Standby when deselected and no write
// - Select only after a seen falling edge
// - Pause tri-states output, ignores clock, data
// - Pause keeps selection and bit position
// - Write protect freezes protect size bits
// - Nothing but memory writes accepted while reset held
// - Reset clears write latch and busy
// - Reset leaves standby, needs fresh edge
// - Main array of 32768 bytes
// - Lockable 64 byte identification page
// - Pause starts only with clock low
// - Pause ends only with clock low
// - Deselect during pause aborts the frame
module spi_eeprom_pin_front_end
   import spi_eeprom_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic srst_i,
   // Serial pins
   input wire logic sck_i,
   input wire logic sdi_i,
   input wire logic cs_n_i,
   input wire logic pause_n_i,
   input wire logic wp_n_i,
   output logic sdo_o,
   output logic sdo_oe_o,
   // Byte stream
   output logic [7:0] rx_byte_o,
   output logic rx_valid_o,
   input wire logic [7:0] tx_byte_i,
   output logic tx_take_o,
   output logic [2:0] bit_count_o,
   // Link state
   output logic selected_o,
   output logic paused_o,
   output logic standby_o,
   output logic frame_end_o,
   output logic frame_abort_o,
   // Status control
   input wire logic wel_set_i,
   input wire logic wel_clr_i,
   input wire logic wip_start_i,
   input wire logic wip_done_i,
   input wire logic [3:0] nv_status_i,
   input wire logic prot_wr_i,
   input wire logic [2:0] prot_data_i,
   input wire logic id_lock_i,
   output logic write_enable_latch_o,
   output logic write_in_progress_o,
   output logic status_lock_bit_o,
   output logic protect_size_hi_o,
   output logic protect_size_lo_o,
   output logic protect_frozen_o,
   output logic id_locked_o,
   // Memory access
   input wire logic [14:0] mem_addr_i,
   input wire logic mem_id_sel_i,
   input wire logic mem_we_i,
   input wire logic [7:0] mem_wdata_i,
   output logic [7:0] mem_rdata_o
);
   // ==========================================================
   // Pin synchronisers
   logic [NPIN-1:0] s1_r, s2_r, s3_r, st_r, st_d_r, st_nxt;

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++)
      begin : g_sync
         always_comb
         begin
            st_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : st_r[gi];
         end
      end
   endgenerate

   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         s1_r <= SYNC_RST;
         s2_r <= SYNC_RST;
         s3_r <= SYNC_RST;
         st_r <= SYNC_RST;
         st_d_r <= SYNC_RST;
      end
      else
      begin
         s1_r <= {wp_n_i, pause_n_i, cs_n_i, sdi_i, sck_i};
         s2_r <= s1_r;
         s3_r <= s2_r;
         st_r <= st_nxt;
         st_d_r <= st_r;
      end
   end

   logic sck_rise, sck_fall, cs_rise, cs_fall, sck_lo, pause_lo;
   assign sck_rise = st_r[PIN_SCK] & ~st_d_r[PIN_SCK];
   assign sck_fall = ~st_r[PIN_SCK] & st_d_r[PIN_SCK];
   assign cs_rise = st_r[PIN_CS] & ~st_d_r[PIN_CS];
   assign cs_fall = ~st_r[PIN_CS] & st_d_r[PIN_CS];
   assign sck_lo = ~st_r[PIN_SCK];
   assign pause_lo = ~st_r[PIN_PAUSE];

   // ==========================================================
   // Link state machine and shifters
   link_state_e state_r, state_nxt;
   logic [2:0] cnt_r, cnt_nxt;
   logic [7:0] rx_sh_r, rx_sh_nxt, tx_sh_r, tx_sh_nxt, rx_byte_nxt;
   logic sdo_nxt, oe_nxt, rx_valid_nxt, take_nxt, end_nxt, abort_nxt;
   logic sel_nxt, paused_nxt, standby_nxt;
   logic wip_r, wip_nxt;

   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      rx_sh_nxt = rx_sh_r;
      tx_sh_nxt = tx_sh_r;
      rx_byte_nxt = rx_byte_o;
      sdo_nxt = sdo_o;
      rx_valid_nxt = 1'b0;
      take_nxt = 1'b0;
      end_nxt = 1'b0;
      abort_nxt = 1'b0;
      case (state_r)
         ST_UNARMED:
         begin
            if (st_r[PIN_CS])
            begin
               state_nxt = ST_DESEL;
            end
         end
         ST_DESEL:
         begin
            if (cs_fall)
            begin
               state_nxt = ST_SEL;
               cnt_nxt = BIT_CNT_RST;
               sdo_nxt = tx_byte_i[7];
               tx_sh_nxt = {tx_byte_i[6:0], 1'b0};
               take_nxt = 1'b1;
            end
         end
         ST_SEL:
         begin
            if (sck_rise)
            begin
               rx_sh_nxt = {rx_sh_r[6:0], st_r[PIN_SDI]};
               cnt_nxt = 3'(cnt_r + 3'h1);
               if (cnt_r == BIT_CNT_LAST)
               begin
                  rx_byte_nxt = {rx_sh_r[6:0], st_r[PIN_SDI]};
                  rx_valid_nxt = 1'b1;
               end
            end
            if (sck_fall)
            begin
               if (cnt_r == BIT_CNT_RST)
               begin
                  sdo_nxt = tx_byte_i[7];
                  tx_sh_nxt = {tx_byte_i[6:0], 1'b0};
                  take_nxt = 1'b1;
               end
               else
               begin
                  sdo_nxt = tx_sh_r[7];
                  tx_sh_nxt = {tx_sh_r[6:0], 1'b0};
               end
            end
            if (cs_rise)
            begin
               state_nxt = ST_DESEL;
               end_nxt = 1'b1;
            end
            // Enter pause only while selected, clock low
            else if (pause_lo && sck_lo)
            begin
               state_nxt = ST_PAUSE;
            end
         end
         ST_PAUSE:
         begin
            if (cs_rise)
            begin
               state_nxt = ST_DESEL;
               cnt_nxt = BIT_CNT_RST;
               abort_nxt = 1'b1;
            end
            else if (!pause_lo && sck_lo)
            begin
               state_nxt = ST_SEL;
            end
         end
         default:
         begin
            state_nxt = ST_UNARMED;
         end
      endcase
      // Drive only while selected and running
      oe_nxt = (state_nxt == ST_SEL);
      sel_nxt = (state_nxt == ST_SEL) || (state_nxt == ST_PAUSE);
      paused_nxt = (state_nxt == ST_PAUSE);
      standby_nxt = !sel_nxt && !wip_nxt;
   end

   // Reset leaves the link unarmed and in standby
   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         state_r <= ST_UNARMED;
         cnt_r <= BIT_CNT_RST;
         rx_sh_r <= BYTE_RST;
         tx_sh_r <= BYTE_RST;
         rx_byte_o <= BYTE_RST;
         sdo_o <= 1'b0;
         sdo_oe_o <= 1'b0;
         rx_valid_o <= 1'b0;
         tx_take_o <= 1'b0;
         frame_end_o <= 1'b0;
         frame_abort_o <= 1'b0;
         selected_o <= 1'b0;
         paused_o <= 1'b0;
         standby_o <= 1'b1;
         bit_count_o <= BIT_CNT_RST;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         rx_sh_r <= rx_sh_nxt;
         tx_sh_r <= tx_sh_nxt;
         rx_byte_o <= rx_byte_nxt;
         sdo_o <= sdo_nxt;
         sdo_oe_o <= oe_nxt;
         rx_valid_o <= rx_valid_nxt;
         tx_take_o <= take_nxt;
         frame_end_o <= end_nxt;
         frame_abort_o <= abort_nxt;
         selected_o <= sel_nxt;
         paused_o <= paused_nxt;
         standby_o <= standby_nxt;
         bit_count_o <= cnt_nxt;
      end
   end

   // ==========================================================
   // Status bits
   logic rst_d_r, wel_nxt, frozen;
   logic [NV_W-1:0] nv_r, nv_nxt;
   eeprom_mem_if mem ();

   // Frozen when lock set and protect pin low
   assign frozen = nv_r[NV_LOCK] & ~st_r[PIN_WP];

   always_comb
   begin
      // Set wins over clear
      wel_nxt = wel_set_i | (write_enable_latch_o & ~wel_clr_i);
      wip_nxt = wip_start_i | (wip_r & ~wip_done_i);
      nv_nxt = nv_r;
      if (rst_d_r)
      begin
         nv_nxt = nv_status_i;
      end
      else
      begin
         if (prot_wr_i && !frozen)
         begin
            nv_nxt[NV_LOCK:NV_LO] = prot_data_i;
         end
         nv_nxt[NV_ID] = nv_r[NV_ID] | id_lock_i;
      end
   end

   // Latch and busy cleared by reset
   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         rst_d_r <= 1'b1;
         write_enable_latch_o <= 1'b0;
         wip_r <= 1'b0;
         nv_r <= NV_RST;
         mem_rdata_o <= BYTE_RST;
         protect_frozen_o <= 1'b0;
      end
      else
      begin
         rst_d_r <= 1'b0;
         write_enable_latch_o <= wel_nxt;
         wip_r <= wip_nxt;
         nv_r <= nv_nxt;
         mem_rdata_o <= mem.rdata;
         protect_frozen_o <= nv_nxt[NV_LOCK] & ~st_nxt[PIN_WP];
      end
   end

   assign write_in_progress_o = wip_r;
   assign status_lock_bit_o = nv_r[NV_LOCK];
   assign protect_size_hi_o = nv_r[NV_HI];
   assign protect_size_lo_o = nv_r[NV_LO];
   assign id_locked_o = nv_r[NV_ID];

   // ==========================================================
   // Byte store
   assign mem.addr = mem_addr_i;
   assign mem.id_sel = mem_id_sel_i;
   assign mem.we = mem_we_i;
   assign mem.wdata = mem_wdata_i;
   assign mem.id_locked = nv_r[NV_ID];

   eeprom_store u_store (
      .clk_sys_i(clk_sys_i),
      .mem(mem.store)
   );

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);

   a_desel_tristate: assert property (
      (state_r == ST_DESEL || state_r == ST_UNARMED) |-> !sdo_oe_o)
      else $error("output driven while deselected");
   a_pause_tristate: assert property (
      state_r == ST_PAUSE && $past(state_r) == ST_PAUSE
      |-> !sdo_oe_o && $stable(sdo_o))
      else $error("output active in pause");
   a_rx_on_rise: assert property (
      rx_valid_o |-> $past(sck_rise) && $past(cnt_r) == BIT_CNT_LAST)
      else $error("byte completed off a rising edge");
   a_tx_on_fall: assert property (
      !$stable(sdo_o) |-> $past(sck_fall) || $past(cs_fall))
      else $error("output changed off a falling edge");
   a_need_edge: assert property (
      state_r == ST_UNARMED |=> state_r != ST_SEL)
      else $error("selected without falling edge");
   a_count_frozen: assert property (
      state_r == ST_PAUSE && $past(state_r) == ST_PAUSE |-> $stable(cnt_r))
      else $error("bit count moved in pause");
   a_pause_entry: assert property (
      state_r == ST_SEL ##1 state_r == ST_PAUSE
      |-> $past(sck_lo) && $past(pause_lo))
      else $error("pause entered with clock high");
   a_pause_exit: assert property (
      state_r == ST_PAUSE ##1 state_r == ST_SEL
      |-> $past(sck_lo) && !$past(pause_lo))
      else $error("pause left with clock high");
   a_pause_abort: assert property (
      state_r == ST_PAUSE && cs_rise
      |=> frame_abort_o && state_r == ST_DESEL && cnt_r == BIT_CNT_RST)
      else $error("deselect in pause did not abort");
   a_protect_freeze: assert property (
      frozen && prot_wr_i && !rst_d_r |=> $stable(nv_r[NV_LOCK:NV_LO]))
      else $error("protect bits changed while frozen");
   a_reset_clears: assert property (
      $fell(srst_i) |-> !write_enable_latch_o && !write_in_progress_o)
      else $error("latch or busy set after reset");
   a_standby_mode: assert property (
      selected_o || write_in_progress_o |-> !standby_o)
      else $error("standby while active");

   c_full_byte: cover property (rx_valid_o);
   c_pause_resume: cover property (
      state_r == ST_PAUSE ##1 state_r == ST_SEL);
   c_abort: cover property (frame_abort_o);
   c_frame_end: cover property (frame_end_o);
endmodule
`default_nettype wire

/* File: inc/spi_eeprom_pkg.sv */
// Constants, pin indices and link states of the serial EEPROM front end.
// Assumes nothing beyond a SystemVerilog compiler.
package spi_eeprom_pkg;
   // ==========================================================
   // Array geometry
   localparam int BYTE_W = 8;
   localparam int MEM_DEPTH = 32768;
   localparam int ID_DEPTH = 64;
   localparam int ADDR_W = 15;
   localparam int ID_AW = 6;
   // ==========================================================
   // Synchronised pin positions and reset image
   localparam int PIN_SCK = 0;
   localparam int PIN_SDI = 1;
   localparam int PIN_CS = 2;
   localparam int PIN_PAUSE = 3;
   localparam int PIN_WP = 4;
   localparam int NPIN = 5;
   localparam logic [4:0] SYNC_RST = 5'h08;
   // ==========================================================
   // Status fields and reset values
   localparam int NV_LO = 0;
   localparam int NV_HI = 1;
   localparam int NV_LOCK = 2;
   localparam int NV_ID = 3;
   localparam int NV_W = 4;
   localparam logic [3:0] NV_RST = 4'h0;
   localparam logic [2:0] BIT_CNT_RST = 3'h0;
   localparam logic [2:0] BIT_CNT_LAST = 3'h7;
   localparam logic [7:0] BYTE_RST = 8'h00;
   // ==========================================================
   // Link states
   typedef enum logic [1:0] {
      ST_UNARMED = 2'b00,
      ST_DESEL = 2'b01,
      ST_SEL = 2'b10,
      ST_PAUSE = 2'b11
   } link_state_e;
endpackage

/* File: inc/eeprom_mem_if.sv */
// Access path between the front end and the byte store.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface eeprom_mem_if;
   import spi_eeprom_pkg::*;
   logic [ADDR_W-1:0] addr;
   logic id_sel;
   logic we;
   logic [BYTE_W-1:0] wdata;
   logic [BYTE_W-1:0] rdata;
   logic id_locked;
   modport ctrl (output addr, id_sel, we, wdata, id_locked, input rdata);
   modport store (input addr, id_sel, we, wdata, id_locked, output rdata);
endinterface
`default_nettype wire

/* File: rtl/eeprom_store.sv */
// Main byte array plus the lockable identification page.
// Assumes writes are presented one byte per cycle on the system clock.
`timescale 1ns/1ps
`default_nettype none
module eeprom_store
   import spi_eeprom_pkg::*;
#(
   parameter int DEPTH = MEM_DEPTH,
   parameter int ID_SIZE = ID_DEPTH
)
(
   // Clock
   input wire logic clk_sys_i,
   // Access path
   eeprom_mem_if.store mem
);
   initial
   begin
      if (DEPTH != (1 << ADDR_W) || ID_SIZE != (1 << ID_AW))
      begin
         $error("eeprom_store: depth does not match address width");
      end
   end

   logic [BYTE_W-1:0] main_mem [DEPTH];
   logic [BYTE_W-1:0] id_mem [ID_SIZE];

   // ==========================================================
   // Storage
   // Main array writes, and identification page writes unless locked
   always_ff @(posedge clk_sys_i)
   begin
      if (mem.we && !mem.id_sel)
      begin
         main_mem[mem.addr] <= mem.wdata;
      end
      if (mem.we && mem.id_sel && !mem.id_locked)
      begin
         id_mem[mem.addr[ID_AW-1:0]] <= mem.wdata;
      end
   end

   always_comb
   begin
      if (mem.id_sel)
      begin
         mem.rdata = id_mem[mem.addr[ID_AW-1:0]];
      end
      else
      begin
         mem.rdata = main_mem[mem.addr];
      end
   end

   // ==========================================================
   // Checks
   a_id_locked_write: assert property (@(posedge clk_sys_i)
      mem.we && mem.id_sel && mem.id_locked
      |=> id_mem[$past(mem.addr[ID_AW-1:0])] ==
      $past(id_mem[mem.addr[ID_AW-1:0]]))
      else $error("locked page was written");
endmodule
`default_nettype wire

/* File: verif/spi_master_model.sv */
// Bus master model driving the serial pins of the EEPROM front end.
// Assumes a 200 ns serial clock, idle low, and a caller that sequences it.
`timescale 1ns/1ps
`default_nettype none
module spi_master_model
(
   // Serial pins
   output logic sck_o,
   output logic sdi_o,
   output logic cs_n_o,
   output logic pause_n_o,
   // Device answer
   input wire logic sdo_i,
   input wire logic sdo_oe_i
);
   localparam time HALF = 100ns;
   // ==========================================================
   // Power-up state: select already low
   initial
   begin
      sck_o = 1'b0;
      sdi_o = 1'b0;
      cs_n_o = 1'b0;
      pause_n_o = 1'b1;
   end
   // ==========================================================
   // Bit transfer
   // MSB first, data set with clock low
   task automatic shift(input int n, input logic [7:0] d,
      output logic [7:0] q);
      q = 8'h00;
      for (int i = 0; i < n; i++)
      begin
         sdi_o = d[7-i];
         #HALF sck_o = 1'b1;
         // Output only changes after the fall
         #HALF q = {q[6:0], sdo_oe_i ? sdo_i : 1'bx};
         sck_o = 1'b0;
      end
   endtask
   // ==========================================================
   // Pause and select
   // Pause moved only with clock low
   task automatic pause(input logic on);
      #HALF pause_n_o = ~on;
      #HALF;
   endtask
   // Released data line shows the inverse value
   task automatic select(input logic on);
      #(HALF + 7ns) cs_n_o = ~on;
      if (!on)
         sdi_o = ~sdi_o;
      #(2 * HALF);
   endtask
endmodule
`default_nettype wire

/* File: verif/spi_eeprom_pin_front_end_tb_top.sv */
// Self-checking bench for the serial EEPROM pin front end.
// Assumes spi_master_model drives the serial pins.
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_pin_front_end_tb_top
   import spi_eeprom_pkg::*;
;
   logic clk_sys_i, srst_i, wp_n_i, wel_set_i, wel_clr_i;
   logic wip_start_i, wip_done_i, prot_wr_i, id_lock_i;
   logic mem_id_sel_i, mem_we_i;
   logic [7:0] tx_byte_i, mem_wdata_i, rx_byte_o, mem_rdata_o, got_rx;
   logic [3:0] nv_status_i;
   logic [2:0] prot_data_i, bit_count_o;
   logic [14:0] mem_addr_i;
   logic sdo_o, sdo_oe_o, rx_valid_o, tx_take_o, selected_o, paused_o;
   logic standby_o, frame_end_o, frame_abort_o, write_enable_latch_o;
   logic write_in_progress_o, status_lock_bit_o, protect_size_hi_o;
   logic protect_size_lo_o, protect_frozen_o, id_locked_o;
   logic [7:0] stat;
   wire logic sck_i, sdi_i, cs_n_i, pause_n_i;
   int error_cnt = 0;
   int cmp_count = 0;
   int n_rx = 0;
   int n_end = 0;
   int n_abort = 0;
   int n_take = 0;
   typedef struct {logic [7:0] mosi; logic [7:0] miso;} row_s;
   row_s rows [4] = '{'{8'ha5, 8'h3c}, '{8'h01, 8'h80},
      '{8'hff, 8'h00}, '{8'h7e, 8'hc3}};
   assign stat = {2'h0, id_locked_o, status_lock_bit_o, protect_size_hi_o,
      protect_size_lo_o, write_enable_latch_o, write_in_progress_o};
   // ==========================================================
   // Design and master
   spi_eeprom_pin_front_end i_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
      .sck_i(sck_i), .sdi_i(sdi_i), .cs_n_i(cs_n_i), .pause_n_i(pause_n_i),
      .wp_n_i(wp_n_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
      .rx_byte_o(rx_byte_o), .rx_valid_o(rx_valid_o), .tx_byte_i(tx_byte_i),
      .tx_take_o(tx_take_o), .bit_count_o(bit_count_o),
      .selected_o(selected_o), .paused_o(paused_o), .standby_o(standby_o),
      .frame_end_o(frame_end_o), .frame_abort_o(frame_abort_o),
      .wel_set_i(wel_set_i), .wel_clr_i(wel_clr_i),
      .wip_start_i(wip_start_i), .wip_done_i(wip_done_i),
      .nv_status_i(nv_status_i), .prot_wr_i(prot_wr_i),
      .prot_data_i(prot_data_i), .id_lock_i(id_lock_i),
      .write_enable_latch_o(write_enable_latch_o),
      .write_in_progress_o(write_in_progress_o),
      .status_lock_bit_o(status_lock_bit_o),
      .protect_size_hi_o(protect_size_hi_o),
      .protect_size_lo_o(protect_size_lo_o),
      .protect_frozen_o(protect_frozen_o), .id_locked_o(id_locked_o),
      .mem_addr_i(mem_addr_i), .mem_id_sel_i(mem_id_sel_i),
      .mem_we_i(mem_we_i), .mem_wdata_i(mem_wdata_i),
      .mem_rdata_o(mem_rdata_o));
   spi_master_model i_master (.sck_o(sck_i), .sdi_o(sdi_i), .cs_n_o(cs_n_i),
      .pause_n_o(pause_n_i), .sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o));
   initial
   begin
      clk_sys_i = 1'b0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   // Pulse catchers
   always @(posedge clk_sys_i)
   begin
      if (rx_valid_o === 1'b1)
      begin
         got_rx <= rx_byte_o;
         n_rx <= n_rx + 1;
      end
      if (frame_end_o === 1'b1)
         n_end <= n_end + 1;
      if (tx_take_o === 1'b1)
         n_take <= n_take + 1;
      if (frame_abort_o === 1'b1)
         n_abort <= n_abort + 1;
   end
   // ==========================================================
   // Helpers
   task automatic step(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask
   task automatic chk8(input logic [7:0] g, input logic [7:0] e,
      input string m);
      cmp_count++;
      if (g !== e)
      begin
         error_cnt++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic chk1(input logic g, input logic e, input string m);
      chk8({7'h00, g}, {7'h00, e}, m);
   endtask
   task automatic chk_n(input int g, input int e, input string m);
      chk8(g[7:0], e[7:0], m);
   endtask
   task automatic finish_test();
      $display("compares %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic frame(input logic [7:0] mo, input logic [7:0] mi);
      logic [7:0] q;
      int r0;
      int e0;
      int t0;
      r0 = n_rx;
      e0 = n_end;
      t0 = n_take;
      tx_byte_i = mi;
      i_master.select(1'b1);
      chk1(standby_o, 1'b0, "active");
      chk1(sdo_oe_o, 1'b1, "driving");
      i_master.shift(8, mo, q);
      step(8);
      chk8(q, mi, "out byte");
      chk8(got_rx, mo, "in byte");
      chk_n(n_rx - r0, 1, "rx pulses");
      chk_n(n_take - t0, 2, "tx takes");
      chk8({5'h00, bit_count_o}, 8'h00, "count wraps");
      i_master.select(1'b0);
      step(8);
      chk1(sdo_oe_o, 1'b0, "released");
      chk1(standby_o, 1'b1, "standby");
      chk_n(n_end - e0, 1, "frame end");
   endtask
   task automatic prot(input logic [2:0] d);
      {prot_data_i, prot_wr_i} = {d, 1'b1};
      step(1);
      prot_wr_i = 1'b0;
      step(2);
   endtask
   task automatic mem_wr(input logic id, input logic [14:0] a,
      input logic [7:0] d);
      {mem_id_sel_i, mem_addr_i, mem_wdata_i, mem_we_i} = {id, a, d, 1'b1};
      step(1);
      mem_we_i = 1'b0;
   endtask
   task automatic mem_rd(input logic id, input logic [14:0] a,
      input logic [7:0] e);
      {mem_id_sel_i, mem_addr_i} = {id, a};
      step(2);
      chk8(mem_rdata_o, e, "mem read");
   endtask
   // ==========================================================
   // Watchdog
   initial
   begin
      #300us;
      error_cnt++;
      finish_test();
   end
   // ==========================================================
   // Tests
   initial
   begin
      logic [7:0] q;
      logic [7:0] d;
      {srst_i, wp_n_i, id_lock_i, mem_id_sel_i, mem_we_i} = 5'h18;
      {wel_set_i, wel_clr_i, wip_start_i, wip_done_i} = 4'h0;
      {prot_wr_i, prot_data_i, tx_byte_i, nv_status_i} = 16'h0007;
      {mem_addr_i, mem_wdata_i} = 23'h000000;
      step(2);
      chk1(standby_o, 1'b1, "reset standby");
      chk1(selected_o, 1'b0, "reset unselected");
      srst_i = 1'b0;
      step(12);
      chk1(selected_o, 1'b0, "low select ignored");
      chk8(stat, 8'h1c, "status after reset");
      $display("test reset done");
      i_master.select(1'b0);
      foreach (rows[i])
         frame(rows[i].mosi, rows[i].miso);
      $display("test rows done");
      {wel_set_i, wip_start_i} = 2'b11;
      step(1);
      {wel_set_i, wip_start_i} = 2'b00;
      step(2);
      chk8(stat, 8'h1f, "latch and busy set");
      chk1(standby_o, 1'b0, "busy not standby");
      {wel_clr_i, wip_done_i} = 2'b11;
      step(1);
      {wel_clr_i, wip_done_i} = 2'b00;
      step(2);
      chk8(stat, 8'h1c, "latch and busy cleared");
      {wel_set_i, wel_clr_i, wip_start_i, wip_done_i} = 4'hf;
      step(1);
      {wel_set_i, wel_clr_i, wip_start_i, wip_done_i} = 4'h0;
      step(2);
      chk8(stat, 8'h1f, "set wins");
      nv_status_i = 4'h6;
      srst_i = 1'b1;
      step(2);
      srst_i = 1'b0;
      step(3);
      chk8(stat, 8'h18, "second reset");
      chk1(standby_o, 1'b1, "standby again");
      $display("test status done");
      wp_n_i = 1'b0;
      step(6);
      prot(3'h0);
      chk1(protect_frozen_o, 1'b1, "frozen");
      chk8(stat, 8'h18, "write refused");
      wp_n_i = 1'b1;
      step(6);
      prot(3'h4);
      chk8(stat, 8'h10, "write taken");
      $display("test protect done");
      mem_wr(1'b0, 15'(MEM_DEPTH - 1), 8'h5a);
      mem_wr(1'b0, 15'h0000, 8'hc3);
      mem_rd(1'b0, 15'(MEM_DEPTH - 1), 8'h5a);
      mem_rd(1'b0, 15'h0000, 8'hc3);
      mem_wr(1'b1, 15'(ID_DEPTH - 1), 8'h96);
      mem_rd(1'b1, 15'(ID_DEPTH - 1), 8'h96);
      id_lock_i = 1'b1;
      step(1);
      id_lock_i = 1'b0;
      mem_wr(1'b1, 15'(ID_DEPTH - 1), 8'h11);
      chk1(id_locked_o, 1'b1, "page locked");
      mem_rd(1'b1, 15'(ID_DEPTH - 1), 8'h96);
      $display("test memory done");
      tx_byte_i = 8'hb4;
      i_master.select(1'b1);
      i_master.shift(4, 8'hc9, q);
      i_master.pause(1'b1);
      step(8);
      chk1(paused_o, 1'b1, "paused");
      chk1(sdo_oe_o, 1'b0, "pause tristate");
      chk1(selected_o, 1'b1, "still selected");
      i_master.shift(3, 8'hff, d);
      step(8);
      chk8({5'h00, bit_count_o}, 8'h04, "count frozen");
      i_master.pause(1'b0);
      step(8);
      chk1(paused_o, 1'b0, "resumed");
      i_master.shift(4, 8'h90, d);
      step(8);
      chk8({q[3:0], d[3:0]}, 8'hb4, "out across pause");
      chk8(got_rx, 8'hc9, "in across pause");
      i_master.select(1'b0);
      step(8);
      $display("test pause done");
      i_master.select(1'b1);
      i_master.shift(3, 8'hff, q);
      i_master.pause(1'b1);
      d = n_end[7:0];
      i_master.select(1'b0);
      step(8);
      chk_n(n_abort, 1, "abort pulse");
      chk8(n_end[7:0], d, "no frame end");
      chk1(selected_o, 1'b0, "abort deselects");
      i_master.pause(1'b0);
      frame(8'h3c, 8'h5a);
      $display("test abort done");
      finish_test();
   end
endmodule
`default_nettype wire
